// *** rtl/itc_cfg.svh ***
// Register addresses, field positions and reset values of the interrupt and timer control block.
`ifndef ITC_CFG_SVH
`define ITC_CFG_SVH
`define ITC_ADDR_TCTL 8'h88
`define ITC_ADDR_PCTL 8'h87
`define ITC_ADDR_IEN 8'hA8
`define ITC_ADDR_IPRI 8'hB8
`define ITC_ADDR_MASK 8'h95
`define ITC_BIT_T1F 7
`define ITC_BIT_T1R 6
`define ITC_BIT_T0F 5
`define ITC_BIT_T0R 4
`define ITC_BIT_X0F 1
`define ITC_BIT_X0T 0
`define ITC_BIT_GEN 7
`define ITC_BIT_DDC 5
`define ITC_BIT_SER 4
`define ITC_BIT_T1 3
`define ITC_BIT_CMB 2
`define ITC_BIT_T0 1
`define ITC_BIT_X0 0
`define ITC_PCTL_BAUD 7
`define ITC_PCTL_UF1 3
`define ITC_PCTL_UF0 2
`define ITC_PCTL_HALT 0
`define ITC_TCTL_WMASK 8'hF3
`define ITC_PCTL_WMASK 8'h8D
`define ITC_IEN_WMASK 8'hBF
`define ITC_IPRI_WMASK 8'h3F
`define ITC_RST_BYTE 8'h00
`define ITC_NSRC 6
`define ITC_VEC_X0 3'h0
`define ITC_VEC_T0 3'h1
`define ITC_VEC_CMB 3'h2
`define ITC_VEC_T1 3'h3
`define ITC_VEC_SER 3'h4
`define ITC_VEC_DDC 3'h5
`define ITC_NSUB 7
`endif

// *** rtl/itc_ctrl.sv ***
// Interrupt request, enable, priority, timer run and power control registers.
`timescale 1ns/1ps
`include "itc_cfg.svh"
module itc_ctrl (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_bit_i,
  input wire logic [2:0] sfr_bit_sel_i,
  input wire logic sfr_rd_i,
  input wire logic timer0_ovf_i,
  input wire logic timer1_ovf_i,
  input wire logic ext_irq0_pin_i,
  input wire logic serial_irq_i,
  input wire logic ddc_irq_i,
  input wire logic [`ITC_NSUB-1:0] sub_src_i,
  input wire logic vector_ack_i,
  input wire logic reti_i,
  output logic [7:0] sfr_rdata_o,
  output logic irq_req_o,
  output itc_pkg::itc_vec_t irq_vec_o,
  output logic timer0_run_o,
  output logic timer1_run_o,
  output logic baud_double_bit_o,
  output logic cpu_halt_mode_bit_o
);
  import itc_pkg::*;

  // Stored registers.
  itc_byte_t tctl;
  itc_byte_t pctl;
  itc_byte_t ien;
  itc_byte_t ipri;
  itc_byte_t interrupt_mask;
  logic [1:0] pin_sync;
  logic pin_prev;
  logic [1:0] in_svc;
  itc_level_e level;

  // The pin feeds the first synchroniser stage and the edge detector reads stage two.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pin_sync <= 2'b11;
      pin_prev <= 1'b1;
    end else begin
      pin_sync <= {pin_sync[0], ext_irq0_pin_i};
      pin_prev <= pin_sync[1];
    end
  end

  // Address and strobe decode; a bit write merges one bit into the old tctl, ien or ipri byte.
  wire sel_tctl = sfr_addr_i == `ITC_ADDR_TCTL;
  wire sel_pctl = sfr_addr_i == `ITC_ADDR_PCTL;
  wire sel_ien = sfr_addr_i == `ITC_ADDR_IEN;
  wire sel_ipri = sfr_addr_i == `ITC_ADDR_IPRI;
  wire sel_mask = sfr_addr_i == `ITC_ADDR_MASK;
  wire [7:0] bit_one = 8'h01 << sfr_bit_sel_i;
  wire [7:0] tctl_new = sfr_bit_i ?
    ((tctl & ~bit_one) | (sfr_wdata_i[0] ? bit_one : 8'h00)) : sfr_wdata_i;
  wire [7:0] ien_new = sfr_bit_i ?
    ((ien & ~bit_one) | (sfr_wdata_i[0] ? bit_one : 8'h00)) : sfr_wdata_i;
  wire [7:0] ipri_new = sfr_bit_i ?
    ((ipri & ~bit_one) | (sfr_wdata_i[0] ? bit_one : 8'h00)) : sfr_wdata_i;
  wire wr_tctl = sfr_wr_i && sel_tctl;
  wire wr_pctl = sfr_wr_i && sel_pctl && !sfr_bit_i;

  // Trigger detection: falling edge or low level per the type bit.
  wire x0_edge = pin_prev && !pin_sync[1];
  wire x0_trig = tctl[`ITC_BIT_X0T] ? x0_edge : !pin_sync[1];

  // Request vector: sources in fixed polling order, index 0 polled first.
  wire cmb_req = |(sub_src_i & ~interrupt_mask[`ITC_NSUB-1:0]);
  wire [`ITC_NSRC-1:0] pend = {ddc_irq_i, serial_irq_i, tctl[`ITC_BIT_T1F], cmb_req,
    tctl[`ITC_BIT_T0F], tctl[`ITC_BIT_X0F]};
  wire [`ITC_NSRC-1:0] en = ien[`ITC_NSRC-1:0] & {`ITC_NSRC{ien[`ITC_BIT_GEN]}};
  wire [`ITC_NSRC-1:0] act = pend & en;
  wire [`ITC_NSRC-1:0] act_hi = act & ipri[`ITC_NSRC-1:0];
  wire [`ITC_NSRC-1:0] act_lo = act & ~ipri[`ITC_NSRC-1:0];

  // Fixed-order pick of the first active source in a vector.
  function automatic itc_vec_t pick(input logic [`ITC_NSRC-1:0] v);
    itc_vec_t r;
    r = 3'h0;
    for (int i = `ITC_NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // A high request may interrupt idle or low service; a low one only idle.
  wire can_hi = |act_hi && !in_svc[1];
  wire can_lo = |act_lo && (in_svc == 2'b00);
  wire next_req = can_hi || can_lo;
  wire itc_vec_t next_vec = can_hi ? pick(act_hi) : pick(act_lo);
  wire ack_hit = vector_ack_i && irq_req_o;
  wire clr_t1 = ack_hit && irq_vec_o == `ITC_VEC_T1;
  wire clr_t0 = ack_hit && irq_vec_o == `ITC_VEC_T0;
  wire clr_x0 = ack_hit && irq_vec_o == `ITC_VEC_X0 && tctl[`ITC_BIT_X0T];

  // Timer control: software bits, hardware flags where a set beats a clear.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tctl <= `ITC_RST_BYTE;
    end else begin
      tctl[`ITC_BIT_T1R] <= wr_tctl ? tctl_new[`ITC_BIT_T1R] : tctl[`ITC_BIT_T1R];
      tctl[`ITC_BIT_T0R] <= wr_tctl ? tctl_new[`ITC_BIT_T0R] : tctl[`ITC_BIT_T0R];
      tctl[`ITC_BIT_X0T] <= wr_tctl ? tctl_new[`ITC_BIT_X0T] : tctl[`ITC_BIT_X0T];
      tctl[`ITC_BIT_T1F] <= timer1_ovf_i ||
        (wr_tctl ? tctl_new[`ITC_BIT_T1F] : tctl[`ITC_BIT_T1F] && !clr_t1);
      tctl[`ITC_BIT_T0F] <= timer0_ovf_i ||
        (wr_tctl ? tctl_new[`ITC_BIT_T0F] : tctl[`ITC_BIT_T0F] && !clr_t0);
      // Level mode flag follows the pin; edge mode latches until serviced.
      tctl[`ITC_BIT_X0F] <= tctl[`ITC_BIT_X0T] ? (x0_trig ||
        (wr_tctl ? tctl_new[`ITC_BIT_X0F] : tctl[`ITC_BIT_X0F] && !clr_x0)) : x0_trig;
      tctl[3:2] <= 2'b00;
    end
  end

  // Power, enable, priority and mask registers; reserved pctl, ien and ipri bits stay zero.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pctl <= `ITC_RST_BYTE;
      ien <= `ITC_RST_BYTE;
      ipri <= `ITC_RST_BYTE;
      interrupt_mask <= `ITC_RST_BYTE;
    end else begin
      if (wr_pctl) begin
        pctl <= sfr_wdata_i & `ITC_PCTL_WMASK;
      end
      if (sfr_wr_i && sel_ien) begin
        ien <= ien_new & `ITC_IEN_WMASK;
      end
      if (sfr_wr_i && sel_ipri) begin
        ipri <= ipri_new & `ITC_IPRI_WMASK;
      end
      if (sfr_wr_i && sel_mask && !sfr_bit_i) begin
        interrupt_mask <= sfr_wdata_i;
      end
    end
  end

  // Service level tracking: ack pushes a level, return pops the highest.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      in_svc <= 2'b00;
      level <= ITC_IDLE;
    end else begin
      if (ack_hit) begin
        in_svc <= in_svc | (ipri[irq_vec_o] ? 2'b10 : 2'b01);
        level <= ipri[irq_vec_o] ? ITC_HIGH : ITC_LOW;
      end else if (reti_i) begin
        in_svc <= in_svc[1] ? {1'b0, in_svc[0]} : 2'b00;
        level <= (in_svc == 2'b11) ? ITC_LOW : ITC_IDLE;
      end
    end
  end

  // Read mux; the mask register is write-only and reads zero.
  wire [7:0] rd_mux = sel_tctl ? tctl : sel_pctl ? pctl : sel_ien ? ien :
    sel_ipri ? ipri : 8'h00;

  // Registered outputs.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sfr_rdata_o <= 8'h00;
      irq_req_o <= 1'b0;
      irq_vec_o <= 3'h0;
      timer0_run_o <= 1'b0;
      timer1_run_o <= 1'b0;
      baud_double_bit_o <= 1'b0;
      cpu_halt_mode_bit_o <= 1'b0;
    end else begin
      sfr_rdata_o <= sfr_rd_i ? rd_mux : 8'h00;
      irq_req_o <= next_req && !ack_hit;
      irq_vec_o <= next_vec;
      timer0_run_o <= tctl[`ITC_BIT_T0R];
      timer1_run_o <= tctl[`ITC_BIT_T1R];
      baud_double_bit_o <= pctl[`ITC_PCTL_BAUD];
      cpu_halt_mode_bit_o <= pctl[`ITC_PCTL_HALT];
    end
  end

  // Checks beside the logic.
  AST_NO_REQ_GLOBAL_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !ien[`ITC_BIT_GEN] && !$past(ien[`ITC_BIT_GEN]) |-> !irq_req_o)
    else $error("Request raised while global enable is off.");
  AST_T1_FLAG_SET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    timer1_ovf_i |=> tctl[`ITC_BIT_T1F]) else $error("Timer 1 overflow flag missed.");
  AST_T0_FLAG_CLR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    clr_t0 && !timer0_ovf_i && !wr_tctl |=> !tctl[`ITC_BIT_T0F])
    else $error("Timer 0 flag not cleared on vector.");
  AST_RUN_FOLLOWS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_tctl |=> ##1 timer0_run_o == $past(tctl_new[`ITC_BIT_T0R], 2))
    else $error("Timer 0 run output wrong.");
  AST_PCTL_NO_BIT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    sfr_wr_i && sel_pctl && sfr_bit_i |=> $stable(pctl))
    else $error("Power control changed by a bit write.");
  AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tctl[3:2] == 2'b00 ##0 ien[6] == 1'b0 ##0 ipri[7:6] == 2'b00)
    else $error("Reserved bit set.");
  AST_EDGE_SET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tctl[`ITC_BIT_X0T] && x0_edge && !$fell(tctl[`ITC_BIT_X0T]) |=> tctl[`ITC_BIT_X0F])
    else $error("External edge flag missed.");
  AST_HIGH_NOT_NESTED: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    in_svc[1] |-> !can_hi && !can_lo) else $error("Request during high service.");

  // Overflow flags set, hold and clear as the core services them.
  AST_T0_FLAG_SET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    timer0_ovf_i |=> tctl[`ITC_BIT_T0F]) else $error("Timer 0 overflow flag missed.");
  AST_T1_FLAG_CLR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    clr_t1 && !timer1_ovf_i && !wr_tctl |=> !tctl[`ITC_BIT_T1F])
    else $error("Timer 1 flag not cleared on vector.");
  AST_T1_FLAG_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tctl[`ITC_BIT_T1F] && !clr_t1 && !wr_tctl |=> tctl[`ITC_BIT_T1F])
    else $error("Timer 1 flag lost.");
  AST_T0_FLAG_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    tctl[`ITC_BIT_T0F] && !clr_t0 && !wr_tctl |=> tctl[`ITC_BIT_T0F])
    else $error("Timer 0 flag lost.");

  // Run outputs follow the software run bits one cycle later.
  AST_T1_RUN_FOLLOWS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_tctl |=> ##1 timer1_run_o == $past(tctl_new[`ITC_BIT_T1R], 2))
    else $error("Timer 1 run output wrong.");
  AST_T0_RUN_REG: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    timer0_run_o == $past(tctl[`ITC_BIT_T0R])) else $error("Timer 0 run lags wrongly.");
  AST_T1_RUN_REG: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    timer1_run_o == $past(tctl[`ITC_BIT_T1R])) else $error("Timer 1 run lags wrongly.");

  // External interrupt flag in edge and level mode.
  AST_EDGE_CLR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    clr_x0 && !x0_trig && !wr_tctl |=> !tctl[`ITC_BIT_X0F])
    else $error("External edge flag not cleared on vector.");
  AST_LEVEL_FOLLOWS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !tctl[`ITC_BIT_X0T] |=> tctl[`ITC_BIT_X0F] == !$past(pin_sync[1]))
    else $error("Level flag does not follow the pin.");
  AST_TYPE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !wr_tctl |=> $stable(tctl[`ITC_BIT_X0T])) else $error("Trigger type changed alone.");

  // A raised request always belongs to an enabled source.
  AST_REQ_NEEDS_GLOBAL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    irq_req_o |-> $past(ien[`ITC_BIT_GEN])) else $error("Request without global enable.");
  AST_DDC_GATE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    irq_req_o && irq_vec_o == `ITC_VEC_DDC |-> $past(ien[`ITC_BIT_DDC]))
    else $error("Disabled I2C request raised.");
  AST_SER_GATE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    irq_req_o && irq_vec_o == `ITC_VEC_SER |-> $past(ien[`ITC_BIT_SER]))
    else $error("Disabled serial request raised.");
  AST_T1_GATE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    irq_req_o && irq_vec_o == `ITC_VEC_T1 |-> $past(ien[`ITC_BIT_T1]))
    else $error("Disabled Timer 1 request raised.");
  AST_T0_GATE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    irq_req_o && irq_vec_o == `ITC_VEC_T0 |-> $past(ien[`ITC_BIT_T0]))
    else $error("Disabled Timer 0 request raised.");
  AST_X0_GATE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    irq_req_o && irq_vec_o == `ITC_VEC_X0 |-> $past(ien[`ITC_BIT_X0]))
    else $error("Disabled external request raised.");
  AST_CMB_GATE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    irq_req_o && irq_vec_o == `ITC_VEC_CMB |-> $past(ien[`ITC_BIT_CMB]))
    else $error("Disabled combined request raised.");
  AST_MASK_BLOCKS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    &interrupt_mask[`ITC_NSUB-1:0] |-> !cmb_req) else $error("Masked sub-source passed.");

  // Priority and nesting of service levels.
  AST_HIGH_FIRST: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    irq_req_o && $past(|act_hi && !in_svc[1]) |-> $past(ipri[next_vec]))
    else $error("Low source chosen over a high one.");
  AST_LEVEL_TRACK: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ((level == ITC_HIGH) == in_svc[1]) && ((level == ITC_IDLE) == (in_svc == 2'b00)))
    else $error("Service level out of step.");
  AST_SVC_POP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    reti_i && !ack_hit && in_svc == 2'b11 |=> in_svc == 2'b01)
    else $error("Return did not resume low service.");
  AST_PREEMPT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    can_hi && !ack_hit |=> irq_req_o) else $error("High request not raised.");
  AST_NO_REQ_AFTER_ACK: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ack_hit |=> !irq_req_o) else $error("Request held after vector.");

  // Power control contents, the levels that it drives and idle read data.
  AST_PCTL_RESERVED: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (pctl & ~`ITC_PCTL_WMASK) == 8'h00) else $error("Reserved power bit set.");
  AST_BAUD_FOLLOWS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    baud_double_bit_o == $past(pctl[`ITC_PCTL_BAUD])) else $error("Baud output wrong.");
  AST_HALT_FOLLOWS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cpu_halt_mode_bit_o == $past(pctl[`ITC_PCTL_HALT])) else $error("Halt output wrong.");
  AST_RD_IDLE_ZERO: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !$past(sfr_rd_i) |-> sfr_rdata_o == 8'h00) else $error("Read data without a read.");
endmodule // itc_ctrl

// *** rtl/itc_pkg.sv ***
// Types shared by the interrupt and timer control block.
package itc_pkg;
  typedef logic [7:0] itc_byte_t;
  typedef logic [2:0] itc_vec_t;
  typedef enum logic [2:0] {
    ITC_IDLE = 3'b001,
    ITC_LOW = 3'b010,
    ITC_HIGH = 3'b100
  } itc_level_e;
endpackage

// *** verification/itc_core_model.sv ***
// Processor core model that vectors to interrupt requests and returns after a service time.
`timescale 1ns/1ps
module itc_core_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic irq_req_i,
  input wire itc_pkg::itc_vec_t irq_vec_i,
  input wire logic slow_i,
  output logic vector_ack_o,
  output logic reti_o,
  output itc_pkg::itc_vec_t last_vec_o,
  output logic [7:0] n_ack_o
);
  import itc_pkg::*;
  logic busy;
  logic [4:0] cnt;
  // Acks a standing request promptly or after a wait, then returns after a long service.
  always_ff @(posedge clk_i) begin
    vector_ack_o <= 1'b0;
    reti_o <= 1'b0;
    if (!rst_b_i) begin
      busy <= 1'b0;
      cnt <= 5'h00;
      last_vec_o <= 3'h0;
      n_ack_o <= 8'h00;
    end else if (busy) begin
      cnt <= cnt + 5'h01;
      busy <= (cnt != 5'h1F);
      reti_o <= (cnt == 5'h1F);
    end else if (irq_req_i && cnt >= (slow_i ? 5'h06 : 5'h00)) begin
      vector_ack_o <= 1'b1;
      last_vec_o <= irq_vec_i;
      n_ack_o <= n_ack_o + 8'h01;
      busy <= 1'b1;
      cnt <= 5'h00;
    end else begin
      cnt <= irq_req_i ? cnt + 5'h01 : 5'h00;
    end
  end
endmodule // itc_core_model

// *** verification/testbench.sv ***
// Self-checking bench for the interrupt and timer control block.
`timescale 1ns/1ps
`include "itc_cfg.svh"
module testbench;
  import itc_pkg::*;
  logic clk_i, rst_b_i, wr, bw, rd, t0, t1, pin, ser, ddc, slow, ack, reti, req, r0, r1, bd, hlt;
  logic [7:0] addr, wd, rdata, nack;
  logic [2:0] bsel;
  logic [6:0] sub;
  itc_vec_t vec, lvec;
  int err_total = 0, n_tests = 0, exp_n = 0;
  logic [7:0] ra [5] = '{`ITC_ADDR_TCTL, `ITC_ADDR_PCTL, `ITC_ADDR_IEN, `ITC_ADDR_IPRI,
                         `ITC_ADDR_MASK};
  logic [7:0] wm [5] = '{8'hF1, 8'h8D, 8'hBF, 8'h3F, 8'h00};
  itc_ctrl DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .sfr_addr_i(addr), .sfr_wdata_i(wd),
    .sfr_wr_i(wr), .sfr_bit_i(bw), .sfr_bit_sel_i(bsel), .sfr_rd_i(rd), .timer0_ovf_i(t0),
    .timer1_ovf_i(t1), .ext_irq0_pin_i(pin), .serial_irq_i(ser), .ddc_irq_i(ddc),
    .sub_src_i(sub), .vector_ack_i(ack), .reti_i(reti), .sfr_rdata_o(rdata), .irq_req_o(req),
    .irq_vec_o(vec), .timer0_run_o(r0), .timer1_run_o(r1), .baud_double_bit_o(bd),
    .cpu_halt_mode_bit_o(hlt));
  itc_core_model CORE (.clk_i(clk_i), .rst_b_i(rst_b_i), .irq_req_i(req), .irq_vec_i(vec),
    .slow_i(slow), .vector_ack_o(ack), .reti_o(reti), .last_vec_o(lvec), .n_ack_o(nack));
  // Free-running 125 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic stop_test();
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One register access; the strobe is held for exactly one sampling edge.
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w, input logic b,
                     input logic [2:0] s);
    @(posedge clk_i);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    bw <= b;
    bsel <= s;
    @(posedge clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    acc(a, d, 1'b1, 1'b0, 3'h0);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    acc(a, 8'h00, 1'b0, 1'b0, 3'h0);
    chk(rdata, e);
  endtask
  // Raises or drops one interrupt source; overflow inputs are single-cycle pulses.
  task automatic src(input int i, input logic on);
    @(posedge clk_i);
    case (i)
      0: pin <= !on;
      1: t0 <= on;
      2: sub <= on ? 7'h7F : 7'h00;
      3: t1 <= on;
      4: ser <= on;
      default: ddc <= on;
    endcase
    @(posedge clk_i);
    t0 <= 1'b0;
    t1 <= 1'b0;
  endtask
  task automatic wack(input itc_vec_t v);
    int k;
    exp_n++;
    for (k = 0; k < 300 && nack !== exp_n[7:0]; k++) @(posedge clk_i);
    if (k == 300) begin
      err_total++;
      $display("mismatch at %0t: no vector acknowledge", $time);
    end else begin
      #1;
      chk({5'h00, lvec}, {5'h00, v});
    end
  endtask
  task automatic quiet();
    repeat (10) @(posedge clk_i);
    #1;
    chk({7'h00, req}, 8'h00);
    chk(nack, exp_n[7:0]);
  endtask
  // Main sequence: reset, register map, sources, masking, priority and trigger type.
  initial begin
    rst_b_i = 1'b0;
    {wr, bw, rd, t0, t1, ser, ddc, slow, addr, wd, bsel, sub} = '0;
    pin = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rchk(ra[i], 8'h00);
      wreg(ra[i], 8'hFF);
      rchk(ra[i], wm[i]);
      wreg(ra[i], 8'h00);
    end
    rchk(8'h99, 8'h00);
    wreg(`ITC_ADDR_PCTL, 8'h81);
    acc(`ITC_ADDR_PCTL, 8'h00, 1'b1, 1'b1, 3'h7);
    acc(`ITC_ADDR_TCTL, 8'h01, 1'b1, 1'b1, 3'h4);
    acc(`ITC_ADDR_TCTL, 8'h01, 1'b1, 1'b1, 3'h6);
    repeat (2) @(posedge clk_i);
    #1;
    chk({4'h0, r1, r0, bd, hlt}, 8'h0F);
    rchk(`ITC_ADDR_PCTL, 8'h81);
    wreg(`ITC_ADDR_TCTL, 8'h41);
    repeat (2) @(posedge clk_i);
    #1;
    chk({6'h00, r1, r0}, 8'h02);
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      wreg(`ITC_ADDR_IEN, 8'h3F);
      src(i, 1'b1);
      quiet();
      if (i == 3) rchk(`ITC_ADDR_TCTL, 8'hC1);
      wreg(`ITC_ADDR_IEN, 8'(8'hBF & ~(8'h01 << i)));
      quiet();
      wreg(`ITC_ADDR_IEN, 8'(8'h80 | (8'h01 << i)));
      wack(i[2:0]);
      src(i, 1'b0);
    end
    rchk(`ITC_ADDR_TCTL, 8'h41);
    wreg(`ITC_ADDR_IEN, 8'h84);
    for (int k = 0; k < 8; k++) begin
      wreg(`ITC_ADDR_MASK, 8'(8'hFF ^ (8'h01 << k)));
      src(2, 1'b1);
      if (k == 7) quiet();
      else wack(3'h2);
      src(2, 1'b0);
    end
    wreg(`ITC_ADDR_MASK, 8'h00);
    for (int j = 0; j < 7; j++) begin
      wreg(`ITC_ADDR_IEN, 8'h00);
      wreg(`ITC_ADDR_IPRI, (j < 6) ? 8'(8'h01 << j) : 8'h00);
      for (int i = 0; i < 6; i++) src(i, 1'b1);
      wreg(`ITC_ADDR_IEN, 8'hBF);
      wack((j < 6) ? j[2:0] : 3'h0);
      for (int i = 0; i < 6; i++) src(i, 1'b0);
      wreg(`ITC_ADDR_TCTL, 8'h41);
      repeat (40) @(posedge clk_i);
    end
    wreg(`ITC_ADDR_IEN, 8'h00);
    wreg(`ITC_ADDR_TCTL, 8'h00);
    src(0, 1'b1);
    quiet();
    rchk(`ITC_ADDR_TCTL, 8'h02);
    src(0, 1'b0);
    quiet();
    rchk(`ITC_ADDR_TCTL, 8'h00);
    stop_test();
  end
endmodule // testbench
